// [shared/i2c_regacc_defines.svh]
// Purpose : Constants for the serial register access target
// Assumes : Included by bare name from package and design files
// Notes   : Definitions only
`ifndef I2C_REGACC_DEFINES_SVH
`define I2C_REGACC_DEFINES_SVH

// Register address field
`define RA_ADDR_W     14
`define RA_DIR_HI     15
`define RA_DIR_LO     14
`define RA_ADDR_RST   14'h0000
`define RA_DIR_RST    2'h0

// Stepping codes carried in the top two address bits
`define RA_DIR_INC    2'h0
`define RA_DIR_DEC    2'h2
`define RA_DIR_FIX    2'h3

// Byte framing
`define RA_BYTE_W     8
`define RA_BIT_ACK    4'h8
`define RA_BIT_POST   4'h9
`define RA_IDX_AHI    2'h0
`define RA_IDX_ALO    2'h1
`define RA_IDX_DATA   2'h2
`define RA_NB_MULTI   2'h2

// Write buffer
`define RA_FIFO_DEPTH 16
`define RA_WORD_W     22

`endif

// [shared/i2c_regacc_pkg.sv]
// Purpose : Types shared by the register access target and its testbench
// Assumes : Constants come from the defines header
// Notes   : Holds types only
`include "i2c_regacc_defines.svh"

package i2c_regacc_pkg;

   // Protocol states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAKE,
      ST_CTRL,
      ST_RX,
      ST_TX,
      ST_IGNORE
   } state_t;

   // One buffered register write
   typedef struct packed {
      logic [`RA_ADDR_W-1:0] addr;
      logic [`RA_BYTE_W-1:0] data;
   } wr_word_t;

endpackage

// [rtl/wr_fifo.sv]
// Purpose : Write buffer between the serial target and the register file
// Assumes : Single clock; read side stalls with out_ready low
// Notes   : Output data and valid come straight from registers
`timescale 1ns/1ns
`default_nettype none

module wr_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,      // Core clock
   input  wire logic             rst_n,     // Async reset, active low
   input  wire logic             in_valid,  // Word offered
   output logic                  in_ready,  // Room for a word
   input  wire logic [WIDTH-1:0] in_data,   // Word in
   output logic                  out_valid, // Word presented
   input  wire logic             out_ready, // Consumer takes word
   output logic      [WIDTH-1:0] out_data   // Word out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // Store accepts while not full; output stage reloads when empty or taken
   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign push     = in_valid & in_ready;
   assign pop      = (count_reg != '0) & (~out_valid | out_ready);

   // Storage array
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Registered output stage
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data  <= mem_reg[rd_ptr_reg];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// [rtl/i2c_regacc.sv]
// Purpose : Serial bus target giving a bus master byte access to registers
// Assumes : Register file on mclk; rd_data valid in the rd_stb cycle
// Notes   : Bus pins are open drain; each byte is one register
`timescale 1ns/1ns
`default_nettype none
`include "i2c_regacc_defines.svh"

module i2c_regacc (
   input  wire logic                   mclk,       // Core clock, 125 MHz
   input  wire logic                   rst_n,      // Async reset, active low
   input  wire logic                   scl_i,      // Bus clock pin level
   output logic                        scl_o,      // Bus clock drive value
   output logic                        scl_oe_n,   // Bus clock drive enable, low drives
   input  wire logic                   sda_i,      // Bus data pin level
   output logic                        sda_o,      // Bus data drive value
   output logic                        sda_oe_n,   // Bus data drive enable, low drives
   input  wire logic                   init_done,  // Internal initialization finished
   input  wire logic                   low_power,  // Device sits in low power
   input  wire logic                   clk_locked, // Internal clocks running and locked
   input  wire logic [6:0]             slave_addr, // Programmed target address
   output logic                        wake_req,   // Request clocks on
   output logic                        sleep_req,  // Pulse: return to power down
   output logic                        irq_n,      // Ready indication, active low
   output logic [`RA_ADDR_W-1:0]       rd_addr,    // Register being read
   output logic                        rd_stb,     // Pulse: capture register value
   input  wire logic [`RA_BYTE_W-1:0]  rd_data,    // Register value at rd_addr
   output logic                        rd_commit,  // Pulse: apply read side effect
   input  wire logic                   evt_in,     // Hardware event for read register
   output logic                        evt_apply,  // Pulse: apply hardware event
   output logic                        wr_valid,   // Write word presented
   input  wire logic                   wr_ready,   // Register file takes write
   output i2c_regacc_pkg::wr_word_t    wr_word     // Write address and data
);
   import i2c_regacc_pkg::*;

   logic [1:0]              pin_s1_reg;
   logic [1:0]              pin_s2_reg;
   logic [1:0]              pin_s3_reg;
   logic [1:0]              pin_f_reg;
   logic [1:0]              pin_d_reg;
   logic                    scl_rise;
   logic                    scl_fall;
   logic                    start_det;
   logic                    stop_det;
   state_t                  state_reg;
   logic [3:0]              bit_cnt_reg;
   logic [7:0]              shift_reg;
   logic [7:0]              tx_reg;
   logic [1:0]              byte_idx_reg;
   logic [1:0]              nbytes_reg;
   logic [5:0]              addr_hi_reg;
   logic [`RA_ADDR_W-1:0]   addr_reg;
   logic [`RA_ADDR_W-1:0]   ptr_reg;
   logic [1:0]              dir_reg;
   logic                    read_reg;
   logic                    armed_reg;
   logic                    woke_reg;
   logic                    cap_req_reg;
   logic                    abort_reg;
   logic                    push_pend_reg;
   wr_word_t                push_word_reg;
   logic                    fifo_in_ready;
   logic                    win_reg;
   logic                    pend_reg;
   logic                    start_ok;
   logic                    ctrl_match;
   logic [`RA_ADDR_W-1:0]   end_addr;

   // Next register address after one byte for the held direction
   function automatic logic [`RA_ADDR_W-1:0] step_addr(
      input logic [`RA_ADDR_W-1:0] a,
      input logic [1:0]            d
   );
      unique case (d)
         `RA_DIR_DEC: step_addr = a - 1'b1;
         `RA_DIR_FIX: step_addr = a;
         default:     step_addr = a + 1'b1;
      endcase
   endfunction

   // Three-stage pin synchronisers; a level counts once stages two and three agree
   genvar g;
   for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            pin_s1_reg[g] <= 1'b1;
            pin_s2_reg[g] <= 1'b1;
            pin_s3_reg[g] <= 1'b1;
            pin_f_reg[g]  <= 1'b1;
            pin_d_reg[g]  <= 1'b1;
         end else begin
            pin_s1_reg[g] <= (g == 0) ? scl_i : sda_i;
            pin_s2_reg[g] <= pin_s1_reg[g];
            pin_s3_reg[g] <= pin_s2_reg[g];
            if (pin_s2_reg[g] == pin_s3_reg[g]) begin
               pin_f_reg[g] <= pin_s3_reg[g];
            end
            pin_d_reg[g] <= pin_f_reg[g];
         end
      end
   end

   // Bus events from the filtered levels; bit 0 is clock, bit 1 is data
   assign scl_rise   = pin_f_reg[0] & ~pin_d_reg[0];
   assign scl_fall   = ~pin_f_reg[0] & pin_d_reg[0];
   assign start_det  = pin_f_reg[0] & pin_d_reg[0] & pin_d_reg[1] & ~pin_f_reg[1];
   assign stop_det   = pin_f_reg[0] & pin_d_reg[0] & ~pin_d_reg[1] & pin_f_reg[1];
   assign start_ok   = start_det & (armed_reg | init_done);
   assign ctrl_match = (shift_reg[7:1] == slave_addr);
   assign end_addr   = (nbytes_reg == `RA_NB_MULTI) ? ptr_reg : addr_reg;

   // Protocol engine
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= 8'h00;
         byte_idx_reg  <= `RA_IDX_AHI;
         nbytes_reg    <= 2'h0;
         addr_hi_reg   <= 6'h00;
         addr_reg      <= `RA_ADDR_RST;
         ptr_reg       <= `RA_ADDR_RST;
         dir_reg       <= `RA_DIR_RST;
         read_reg      <= 1'b0;
         armed_reg     <= 1'b0;
         woke_reg      <= 1'b0;
         cap_req_reg   <= 1'b0;
         abort_reg     <= 1'b0;
         sleep_req     <= 1'b0;
         sda_oe_n      <= 1'b1;
         push_pend_reg <= 1'b0;
         push_word_reg <= '0;
      end else begin
         cap_req_reg <= 1'b0;
         abort_reg   <= 1'b0;
         sleep_req   <= 1'b0;
         if (push_pend_reg && fifo_in_ready) begin
            push_pend_reg <= 1'b0;
         end
         if (!armed_reg && !start_ok) begin
            sda_oe_n <= 1'b1;
         end else if (stop_det || start_ok) begin
            // Any Start or Stop ends the transfer and releases data at once
            armed_reg   <= 1'b1;
            abort_reg   <= 1'b1;
            sda_oe_n    <= 1'b1;
            addr_reg    <= end_addr;
            ptr_reg     <= end_addr;
            nbytes_reg  <= 2'h0;
            bit_cnt_reg <= 4'h0;
            woke_reg    <= start_ok & low_power;
            if (stop_det) begin
               state_reg <= ST_IDLE;
            end else if (low_power) begin
               state_reg <= ST_WAKE;
            end else begin
               state_reg <= ST_CTRL;
            end
         end else begin
            unique case (state_reg)
               ST_IDLE, ST_IGNORE: begin
               end
               ST_WAKE: begin
                  if (clk_locked) begin
                     state_reg <= ST_CTRL;
                  end
               end
               ST_CTRL, ST_RX: begin
                  if (scl_rise && bit_cnt_reg < `RA_BIT_ACK) begin
                     shift_reg   <= {shift_reg[6:0], pin_f_reg[1]};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == `RA_BIT_ACK && sda_oe_n) begin
                     if (state_reg == ST_CTRL) begin
                        if (ctrl_match) begin
                           sda_oe_n     <= 1'b0;
                           read_reg     <= shift_reg[0];
                           byte_idx_reg <= `RA_IDX_AHI;
                        end else begin
                           state_reg <= ST_IGNORE;
                           sleep_req <= woke_reg;
                        end
                     end else begin
                        sda_oe_n <= 1'b0;
                        unique case (byte_idx_reg)
                           `RA_IDX_AHI: begin
                              addr_hi_reg  <= shift_reg[5:0];
                              dir_reg      <= shift_reg[7:6];
                              byte_idx_reg <= `RA_IDX_ALO;
                           end
                           `RA_IDX_ALO: begin
                              addr_reg     <= {addr_hi_reg, shift_reg};
                              ptr_reg      <= {addr_hi_reg, shift_reg};
                              byte_idx_reg <= `RA_IDX_DATA;
                           end
                           default: begin
                              // Only whole bytes are queued; a cut byte is dropped
                              push_pend_reg      <= 1'b1;
                              push_word_reg.addr <= ptr_reg;
                              push_word_reg.data <= shift_reg;
                              ptr_reg            <= step_addr(ptr_reg, dir_reg);
                              if (nbytes_reg != `RA_NB_MULTI) begin
                                 nbytes_reg <= nbytes_reg + 2'h1;
                              end
                           end
                        endcase
                     end
                  end else if (scl_rise && bit_cnt_reg == `RA_BIT_ACK) begin
                     bit_cnt_reg <= `RA_BIT_POST;
                     cap_req_reg <= (state_reg == ST_CTRL) & read_reg;
                  end else if (scl_fall && bit_cnt_reg == `RA_BIT_POST) begin
                     bit_cnt_reg <= 4'h0;
                     if (state_reg == ST_CTRL && read_reg) begin
                        state_reg <= ST_TX;
                        sda_oe_n  <= tx_reg[7];
                        shift_reg <= {tx_reg[6:0], 1'b0};
                     end else begin
                        state_reg <= ST_RX;
                        sda_oe_n  <= 1'b1;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise && bit_cnt_reg == `RA_BIT_ACK) begin
                     // Byte fully sent: commit side effect and step the pointer
                     ptr_reg <= step_addr(ptr_reg, dir_reg);
                     if (nbytes_reg != `RA_NB_MULTI) begin
                        nbytes_reg <= nbytes_reg + 2'h1;
                     end
                     if (!pin_f_reg[1]) begin
                        bit_cnt_reg <= `RA_BIT_POST;
                        cap_req_reg <= 1'b1;
                     end else begin
                        state_reg <= ST_IGNORE;
                     end
                  end else if (scl_rise) begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == `RA_BIT_ACK) begin
                     sda_oe_n <= 1'b1;
                  end else if (scl_fall && bit_cnt_reg == `RA_BIT_POST) begin
                     bit_cnt_reg <= 4'h0;
                     sda_oe_n    <= tx_reg[7];
                     shift_reg   <= {tx_reg[6:0], 1'b0};
                  end else if (scl_fall) begin
                     sda_oe_n  <= shift_reg[7];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // Register read port: capture strobe, latched data and side-effect commit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_addr   <= `RA_ADDR_RST;
         rd_stb    <= 1'b0;
         rd_commit <= 1'b0;
         tx_reg    <= 8'h00;
      end else begin
         rd_stb    <= cap_req_reg;
         rd_commit <= (state_reg == ST_TX) & scl_rise & (bit_cnt_reg == `RA_BIT_ACK)
                      & ~stop_det & ~start_ok;
         if (cap_req_reg) begin
            rd_addr <= ptr_reg;
         end
         if (rd_stb) begin
            tx_reg <= rd_data;
         end
      end
   end

   // Events during a capture-to-commit window wait until after the commit or an abort
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         win_reg   <= 1'b0;
         pend_reg  <= 1'b0;
         evt_apply <= 1'b0;
      end else begin
         if (rd_stb) begin
            win_reg <= 1'b1;
         end else if (rd_commit || abort_reg) begin
            win_reg <= 1'b0;
         end
         if ((win_reg || rd_stb) && !rd_commit && !abort_reg) begin
            evt_apply <= 1'b0;
            pend_reg  <= pend_reg | evt_in;
         end else begin
            evt_apply <= pend_reg | evt_in;
            pend_reg  <= 1'b0;
         end
      end
   end

   // Clock stretch, wake, ready indication and drive values
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe_n <= 1'b1;
         scl_o    <= 1'b0;
         sda_o    <= 1'b0;
         wake_req <= 1'b0;
         irq_n    <= 1'b1;
      end else begin
         scl_oe_n <= ~((state_reg == ST_WAKE && !clk_locked)
                       || (push_pend_reg && !fifo_in_ready));
         scl_o    <= 1'b0;
         sda_o    <= 1'b0;
         wake_req <= (state_reg == ST_WAKE);
         irq_n    <= ~(init_done & ~armed_reg);
      end
   end

   wr_fifo #(
      .WIDTH (`RA_WORD_W),
      .DEPTH (`RA_FIFO_DEPTH)
   ) u_wr_fifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (push_pend_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word_reg),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_word)
   );

   // Checks
   sequence s_ctrl_decide;
      state_reg == ST_CTRL && scl_fall && bit_cnt_reg == `RA_BIT_ACK && sda_oe_n
      && !stop_det && !start_ok;
   endsequence

   sequence s_cap;
      cap_req_reg ##1 rd_stb;
   endsequence

   chk_uninit_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      !armed_reg |=> sda_oe_n) else $error("data driven before arming");
   chk_arm_start: assert property (@(posedge mclk) disable iff (!rst_n)
      !armed_reg && init_done && start_det |=> armed_reg && state_reg != ST_IDLE)
      else $error("first start after init not taken");
   chk_ready_irq: assert property (@(posedge mclk) disable iff (!rst_n)
      init_done && !armed_reg |=> !irq_n) else $error("ready not signalled");
   chk_wake_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == ST_WAKE && !clk_locked |=> !scl_oe_n)
      else $error("clock not stretched while waking");
   chk_miss_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
      s_ctrl_decide and (!ctrl_match && woke_reg) |=> sleep_req && state_reg == ST_IGNORE)
      else $error("mismatch after wake did not power down");
   chk_ctrl_ack: assert property (@(posedge mclk) disable iff (!rst_n)
      s_ctrl_decide and ctrl_match |=> !sda_oe_n [*1] ##1 $stable(read_reg))
      else $error("matching control byte not acknowledged");
   chk_abort_release: assert property (@(posedge mclk) disable iff (!rst_n)
      armed_reg && (start_det || stop_det) |=> sda_oe_n && !rd_commit)
      else $error("data still driven after start or stop");
   chk_capture_data: assert property (@(posedge mclk) disable iff (!rst_n)
      s_cap |=> tx_reg == $past(rd_data)) else $error("read value not latched");
   chk_event_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      win_reg && evt_in && !rd_commit && !abort_reg |=> pend_reg && !evt_apply)
      else $error("event not held during read window");
   chk_event_apply: assert property (@(posedge mclk) disable iff (!rst_n)
      pend_reg && rd_commit |=> evt_apply && !pend_reg)
      else $error("held event not applied after commit");
   chk_fix_step: assert property (@(posedge mclk) disable iff (!rst_n)
      state_reg == ST_TX && dir_reg == `RA_DIR_FIX && scl_rise
      && bit_cnt_reg == `RA_BIT_ACK && !start_ok && !stop_det |=> $stable(ptr_reg))
      else $error("fixed direction moved the address");

endmodule

`default_nettype wire

// [verif/i2c_master_model.sv]
// Purpose: bus master stand-in for the register access target
// Assumes: open drain lines with pull-ups, 1 releases a line
// Notes: bus clock period about 125 ns, stretching waited out
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
   input  wire logic scl_in, // Clock line level
   input  wire logic sda_in, // Data line level
   output var logic  scl_m,  // Clock drive, 0 pulls low
   output var logic  sda_m   // Data drive, 0 pulls low
);
   logic r;
   initial {scl_m, sda_m} = 2'h3;
   // One bit; a held-low clock delays the high phase
   task automatic bit_io(input logic b, output logic q);
      sda_m = b;
      #31 scl_m = 1'b1;
      for (int n = 0; n < 9000 && scl_in !== 1'b1; n++) #8;
      #31 q = sda_in;
      #31 scl_m = 1'b0;
      #31;
   endtask
   // Start when s is 1, Stop when s is 0
   task automatic cond(input logic s);
      sda_m = s;
      #31 scl_m = 1'b1;
      #31 sda_m = !s;
      #31 scl_m = !s;
      #31;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask
endmodule
`default_nettype wire

// [verif/i2c_register_access_slave_tb.sv]
// Purpose: self-checking bench for the register access target
// Assumes: array as register file, master model on the bus
// Notes: random data and stalls from seed 62
`timescale 1ns/1ns
`default_nettype none
module i2c_register_access_slave_tb;
   import i2c_regacc_pkg::*;
   logic mclk = 0, rst_n = 0, init_done = 0, low_power = 0, clk_locked = 1, wr_ready = 1;
   logic scl_oe_n, sda_oe_n, wake_req, sleep_req, irq_n, wr_valid, scl_m, sda_m, ack;
   logic w_s = 0, s_s = 0;
   logic scl_o, sda_o, rd_stb, rd_commit, evt_apply;
   logic evt = 0, ev_on = 1, in_win = 0, ev_open = 0;
   int n_stb = 0, n_cmt = 0, n_bad = 0;
   logic [13:0] rd_addr, b, a;
   logic [7:0] v, mem [16384], xm [16384];
   wr_word_t wr_word;
   int miscompares = 0, tests_run = 0, dir;
   wire scl = scl_m & (scl_oe_n | scl_o);
   wire sda = sda_m & (sda_oe_n | sda_o);
   i2c_master_model bus (.scl_in(scl), .sda_in(sda), .scl_m(scl_m), .sda_m(sda_m));
   i2c_regacc uut (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .init_done(init_done), .irq_n(irq_n),
      .low_power(low_power), .clk_locked(clk_locked), .slave_addr(7'h2A), .rd_stb(rd_stb),
      .wake_req(wake_req), .sleep_req(sleep_req), .rd_addr(rd_addr), .rd_commit(rd_commit),
      .rd_data(mem[rd_addr]), .evt_in(evt), .evt_apply(evt_apply), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_word(wr_word));
   always #4 mclk = ~mclk;
   // Register file takes buffered writes and stalls at random
   always @(posedge mclk) begin
      if (wr_valid && wr_ready) mem[wr_word.addr] <= wr_word.data;
      w_s <= w_s | wake_req;
      s_s <= s_s | sleep_req;
      wr_ready <= #1 1'($urandom % 3 != 0);
      // Random hardware events; none may be applied between capture and commit
      evt <= #1 ev_on & 1'($urandom % 16 == 0);
      n_stb <= n_stb + int'(rd_stb);
      n_cmt <= n_cmt + int'(rd_commit);
      if (rd_stb) in_win <= 1'b1;
      else if (rd_commit) in_win <= 1'b0;
      if (in_win && evt_apply) n_bad <= n_bad + 1;
      if (evt) ev_open <= 1'b1;
      else if (evt_apply) ev_open <= 1'b0;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask
   function automatic logic [13:0] step(input logic [13:0] p);
      return (dir == 2) ? p - 14'h0001 : (dir == 3) ? p : p + 14'h0001;
   endfunction
   // Control byte, then the address high byte first when wa is set
   task automatic head(input logic rw, input logic wa);
      bus.cond(1'b1);
      bus.wbyte({7'h2A, rw}, ack);
      check("ctrl ack", 8'(ack), 8'h01);
      if (wa) bus.wbyte({2'(dir), b[13:8]}, ack);
      if (wa) bus.wbyte(b[7:0], ack);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      void'($urandom(62));
      repeat (5) @(posedge mclk);
      #1 rst_n = 1'b1;
      // Uninitialized: control byte must go unanswered
      bus.cond(1'b1);
      bus.wbyte(8'h54, ack);
      check("early ack", 8'(ack), 8'h00);
      bus.cond(1'b0);
      $display("uninit done");
      @(posedge mclk);
      #1 init_done = 1'b1;
      repeat (4) @(posedge mclk);
      check("ready irq", 8'(irq_n), 8'h00);
      // Three bytes written and read back for each stepping code, wrap corners first
      for (int k = 0; k < 3; k++) begin
         dir = (k == 0) ? 0 : k + 1;
         b = (k == 0) ? 14'h3FFE : (k == 1) ? 14'h0001 : 14'($urandom);
         head(1'b0, 1'b1);
         if (k == 0) check("irq off", 8'(irq_n), 8'h01);
         a = b;
         repeat (3) begin
            v = 8'($urandom);
            bus.wbyte(v, ack);
            check("data ack", 8'(ack), 8'h01);
            xm[a] = v;
            a = step(a);
         end
         head(1'b0, 1'b1); // Address set before reading
         head(1'b1, 1'b0);
         a = b;
         for (int j = 0; j < 3; j++) begin
            bus.rbyte(j == 2, v);
            check("read data", v, xm[a]);
            a = step(a);
         end
         bus.cond(1'b0);
         $display("stepping %0d done", dir);
      end
      // Asleep: clock held until locked, wrong address powers down again
      @(posedge mclk);
      #1 low_power = 1'b1;
      clk_locked = 1'b0;
      fork
         begin
            bus.cond(1'b1);
            bus.wbyte(8'h57, ack);
            bus.cond(1'b0);
         end
         begin
            repeat (80) @(posedge mclk);
            check("stretch", 8'(scl), 8'h00);
            #1 clk_locked = 1'b1;
         end
      join
      check("mismatch ack", 8'(ack), 8'h00);
      check("wake", 8'(w_s), 8'h01);
      check("sleep", 8'(s_s), 8'h01);
      // Three reads of three bytes each: one capture and one commit per byte
      ev_on = 1'b0;
      repeat (4) @(posedge mclk);
      check("captures", 8'(n_stb), 8'h09);
      check("commits", 8'(n_cmt), 8'h09);
      check("early events", 8'(n_bad), 8'h00);
      check("lost events", 8'(ev_open), 8'h00);
      $display("wake done");
      end_sim();
   end
   initial begin
      #400000;
      miscompares++;
      end_sim();
   end
endmodule
`default_nettype wire
